// >>> core/bss_pkg.sv
/*
  constants for the boot source selector: mode codes, boot sources,
  host interface choices, sequence states and sizing figures.
  assumes nothing beyond a systemverilog compiler.
*/
package bss_pkg;

  // ---------------------------------------------------------------
  // selection codes
  // ---------------------------------------------------------------
  localparam int          MODE_W          = 5;
  localparam logic [4:0]  MODE_EEPROM_SPI = 5'h03;
  localparam logic [4:0]  MODE_TWOWIRE    = 5'h0a;
  localparam logic [4:0]  MODE_SERIAL     = 5'h10;
  localparam logic [4:0]  MODE_SDIO       = 5'h12;
  localparam logic [4:0]  MODE_EEPROM_SD  = 5'h13;
  localparam logic [4:0]  MODE_UART_REF   = 5'h1d;
  localparam logic [4:0]  MODE_UART_PLL   = 5'h1e;

  // ---------------------------------------------------------------
  // boot source and host interface encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BSS_SRC_NONE    = 3'h0,
    BSS_SRC_SERIAL  = 3'h1,
    BSS_SRC_SDIO    = 3'h2,
    BSS_SRC_SPI_ROM = 3'h3,
    BSS_SRC_I2C_ROM = 3'h4,
    BSS_SRC_UART    = 3'h5
  } bss_src_t;

  typedef enum logic [1:0] {
    BSS_HOST_NONE   = 2'h0,
    BSS_HOST_SERIAL = 2'h1,
    BSS_HOST_SDIO   = 2'h2,
    BSS_HOST_UART   = 2'h3
  } bss_host_t;

  typedef enum logic [1:0] {
    BSS_CLK_MAIN    = 2'h0,
    BSS_CLK_REF40   = 2'h1,
    BSS_CLK_PLL120  = 2'h2
  } bss_clk_t;

  // ---------------------------------------------------------------
  // sequence states, gray along the usual path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BSS_ST_SAMPLE = 3'b000,
    BSS_ST_CONFIG = 3'b001,
    BSS_ST_LOAD   = 3'b011,
    BSS_ST_PERIPH = 3'b010,
    BSS_ST_DONE   = 3'b110,
    BSS_ST_HALT   = 3'b111
  } bss_state_t;

  // ---------------------------------------------------------------
  // sizing
  // ---------------------------------------------------------------
  localparam int          IMAGE_KBYTES    = 240;
  localparam int          IMAGE_BYTES     = IMAGE_KBYTES * 1024;
  localparam int          CNT_W           = 18;
  localparam int          ROM_DEPTH       = 8;
  localparam int          ROM_AW          = 3;
  localparam int          ROM_DW          = 8;
  localparam logic [1:0]  STRAP_SYNC_N    = 2'h2;

endpackage

// >>> core/bss_rom.sv
/*
  small loader rom: one sequence of step codes, the same for every source, read by the
  selector while it sets up the boot interface.
  assumes synchronous read on sys_clk.
*/
`timescale 1ns/10ps
module bss_rom
(
  // clock
  input  wire logic                      sys_clk,
  // read port
  input  wire logic [bss_pkg::ROM_AW-1:0] rom_addr,
  output      logic [bss_pkg::ROM_DW-1:0] rom_data
);

  // ---------------------------------------------------------------
  // contents
  // ---------------------------------------------------------------
  logic [bss_pkg::ROM_DW-1:0] mem [bss_pkg::ROM_DEPTH];

  // step codes: pin mux, clock setup, interface enable, then end
  assign mem[0] = 8'h11;
  assign mem[1] = 8'h22;
  assign mem[2] = 8'h33;
  assign mem[3] = 8'h44;
  assign mem[4] = 8'h55;
  assign mem[5] = 8'h66;
  assign mem[6] = 8'h77;
  assign mem[7] = 8'hff;

  always_ff @(posedge sys_clk)
  begin
    rom_data <= mem[rom_addr];
  end

endmodule // bss_rom

// >>> core/bss_boot_selector.sv
/*
  boot source selector: samples the mode strap after reset, decodes the
  boot source and host interface, steps through configuration, firmware
  load and peripheral setup, and reports reserved codes.
  assumes the loaded byte stream is delivered with a valid strobe from
  the chosen interface on sys_clk, and peripheral setup acks likewise.
*/
`timescale 1ns/10ps

// Overview of operation
// RULE1 - five-bit mode strap is sampled at reset and chooses the boot source
// RULE2 - boot via sdio host, serial host port, or eeprom on spi pins
// RULE3 - code 0 0011 boots spi eeprom, serial host port on spi pins
// RULE4 - order is configure interface, load firmware, then set up peripherals
// RULE5 - loader can move a firmware image of about 240 kbytes
// RULE6 - transfer code is held in a small loader rom
// RULE7 - code 1 0000 boots serial host port, 1 0010 boots sdio host
// RULE8 - code 1 0011 boots spi eeprom or flash, sdio as host interface
// RULE9 - code 0 1010 boots two-wire eeprom, serial host port on spi pins
// RULE10 - 1 1101 uart on 40 mhz reference, 1 1110 uart on pll 120 mhz
// RULE11 - reserved codes start no transfer; block idles and flags it
module bss_boot_selector
#(
  parameter int IMAGE_BYTES = bss_pkg::IMAGE_BYTES
)
(
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // strap pins
  input  wire logic [bss_pkg::MODE_W-1:0] mode_pins,
  // firmware stream from the selected interface
  input  wire logic                       fw_valid,
  // peripheral setup acknowledge
  input  wire logic                       periph_ack,
  // decoded selection
  output      logic [2:0]                 boot_src,
  output      logic [1:0]                 host_if,
  output      logic [1:0]                 sys_clk_sel,
  output      logic [bss_pkg::MODE_W-1:0] mode_latched,
  // sequence status
  output      logic                       cfg_active,
  output      logic [bss_pkg::ROM_DW-1:0] cfg_step,
  output      logic                       load_active,
  output      logic                       periph_active,
  output      logic                       boot_done,
  output      logic                       mode_reserved
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  typedef struct packed {
    bss_pkg::bss_src_t  src;
    bss_pkg::bss_host_t host;
    bss_pkg::bss_clk_t  clk;
  } bss_sel_t;

  function automatic bss_sel_t bss_decode(input logic [4:0] code);
    bss_sel_t s;
    s = '{bss_pkg::BSS_SRC_NONE, bss_pkg::BSS_HOST_NONE,
          bss_pkg::BSS_CLK_MAIN};
    unique case (code)
      bss_pkg::MODE_EEPROM_SPI: s = '{bss_pkg::BSS_SRC_SPI_ROM, // RULE3
        bss_pkg::BSS_HOST_SERIAL, bss_pkg::BSS_CLK_MAIN};
      bss_pkg::MODE_TWOWIRE:    s = '{bss_pkg::BSS_SRC_I2C_ROM, // RULE9
        bss_pkg::BSS_HOST_SERIAL, bss_pkg::BSS_CLK_MAIN};
      bss_pkg::MODE_SERIAL:     s = '{bss_pkg::BSS_SRC_SERIAL, // RULE7
        bss_pkg::BSS_HOST_SERIAL, bss_pkg::BSS_CLK_MAIN};
      bss_pkg::MODE_SDIO:       s = '{bss_pkg::BSS_SRC_SDIO, // RULE7
        bss_pkg::BSS_HOST_SDIO, bss_pkg::BSS_CLK_MAIN};
      bss_pkg::MODE_EEPROM_SD:  s = '{bss_pkg::BSS_SRC_SPI_ROM, // RULE8
        bss_pkg::BSS_HOST_SDIO, bss_pkg::BSS_CLK_MAIN};
      bss_pkg::MODE_UART_REF:   s = '{bss_pkg::BSS_SRC_UART, // RULE10
        bss_pkg::BSS_HOST_UART, bss_pkg::BSS_CLK_REF40};
      bss_pkg::MODE_UART_PLL:   s = '{bss_pkg::BSS_SRC_UART, // RULE10
        bss_pkg::BSS_HOST_UART, bss_pkg::BSS_CLK_PLL120};
      default:                  s = s; // RULE11
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // strap synchroniser
  // ---------------------------------------------------------------
  // pins are asynchronous to sys_clk; two stages before decode
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end
    else
    begin
      sync1_r <= mode_pins;
      sync2_r <= sync1_r;
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  localparam int                        CW        = bss_pkg::CNT_W;
  localparam logic [bss_pkg::CNT_W-1:0] LAST_BYTE = CW'(IMAGE_BYTES - 1);

  bss_pkg::bss_state_t           state_r, state_nxt;
  logic [1:0]                    wait_r, wait_nxt;
  logic [4:0]                    mode_r, mode_nxt;
  bss_sel_t                      sel_r, sel_nxt;
  logic [bss_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
  logic [bss_pkg::ROM_AW-1:0]    raddr_r, raddr_nxt;
  logic                          rvalid_r, rvalid_nxt;
  logic [bss_pkg::ROM_DW-1:0]    step_r, step_nxt;
  logic                          resv_r, resv_nxt;
  logic [bss_pkg::ROM_DW-1:0]    rom_q;
  bss_sel_t                      dec;

  // loader steps come from rom rather than fixed logic
  bss_rom bss_rom_inst
  (
    .sys_clk  (sys_clk),
    .rom_addr (raddr_r),
    .rom_data (rom_q)
  ); // RULE6

  always_comb
  begin
    dec        = bss_decode(sync2_r);
    state_nxt  = state_r;
    wait_nxt   = wait_r;
    mode_nxt   = mode_r;
    sel_nxt    = sel_r;
    cnt_nxt    = cnt_r;
    raddr_nxt  = raddr_r;
    rvalid_nxt = 1'b0;
    step_nxt   = step_r;
    resv_nxt   = resv_r;
    unique case (state_r)
      bss_pkg::BSS_ST_SAMPLE:
      begin
        // wait until the synchroniser holds a clean strap value
        if (wait_r != bss_pkg::STRAP_SYNC_N)
          wait_nxt = wait_r + 2'h1;
        else
        begin
          mode_nxt = sync2_r; // RULE1
          sel_nxt  = dec;
          if (dec.src == bss_pkg::BSS_SRC_NONE)
          begin
            resv_nxt  = 1'b1; // RULE11
            state_nxt = bss_pkg::BSS_ST_HALT;
          end
          else
            state_nxt = bss_pkg::BSS_ST_CONFIG; // RULE2
        end
      end
      bss_pkg::BSS_ST_CONFIG:
      begin
        raddr_nxt  = raddr_r + 3'h1;
        rvalid_nxt = 1'b1;
        if (rvalid_r)
          step_nxt = rom_q;
        if (rvalid_r && rom_q == 8'hff)
          state_nxt = bss_pkg::BSS_ST_LOAD; // RULE4
      end
      bss_pkg::BSS_ST_LOAD:
      begin
        if (fw_valid)
        begin
          cnt_nxt = cnt_r + 18'h00001; // RULE5
          if (cnt_r == LAST_BYTE)
            state_nxt = bss_pkg::BSS_ST_PERIPH; // RULE4
        end
      end
      bss_pkg::BSS_ST_PERIPH:
      begin
        if (periph_ack)
          state_nxt = bss_pkg::BSS_ST_DONE; // RULE4
      end
      bss_pkg::BSS_ST_DONE: state_nxt = state_r;
      bss_pkg::BSS_ST_HALT: state_nxt = state_r; // RULE11
      default:              state_nxt = bss_pkg::BSS_ST_HALT;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= bss_pkg::BSS_ST_SAMPLE;
      wait_r   <= 2'h0;
      mode_r   <= 5'h00;
      sel_r    <= '{bss_pkg::BSS_SRC_NONE, bss_pkg::BSS_HOST_NONE,
                    bss_pkg::BSS_CLK_MAIN};
      cnt_r    <= '0;
      raddr_r  <= '0;
      rvalid_r <= 1'b0;
      step_r   <= 8'h00;
      resv_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      wait_r   <= wait_nxt;
      mode_r   <= mode_nxt;
      sel_r    <= sel_nxt;
      cnt_r    <= cnt_nxt;
      raddr_r  <= raddr_nxt;
      rvalid_r <= rvalid_nxt;
      step_r   <= step_nxt;
      resv_r   <= resv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // registered status outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_src      <= 3'h0;
      host_if       <= 2'h0;
      sys_clk_sel   <= 2'h0;
      mode_latched  <= 5'h00;
      cfg_active    <= 1'b0;
      cfg_step      <= 8'h00;
      load_active   <= 1'b0;
      periph_active <= 1'b0;
      boot_done     <= 1'b0;
      mode_reserved <= 1'b0;
    end
    else
    begin
      boot_src      <= sel_nxt.src;
      host_if       <= sel_nxt.host;
      sys_clk_sel   <= sel_nxt.clk;
      mode_latched  <= mode_nxt;
      cfg_active    <= (state_nxt == bss_pkg::BSS_ST_CONFIG);
      cfg_step      <= step_nxt;
      load_active   <= (state_nxt == bss_pkg::BSS_ST_LOAD);
      periph_active <= (state_nxt == bss_pkg::BSS_ST_PERIPH);
      boot_done     <= (state_nxt == bss_pkg::BSS_ST_DONE);
      mode_reserved <= resv_nxt;
    end
  end

endmodule // bss_boot_selector

// >>> sim/bss_expect.svh
/* expected {source, host, clock} decode of each strap code.
   assumes inclusion inside a module body. */
function automatic logic [6:0] bss_expect(input logic [4:0] m);
  case (m)
    5'h03: return 7'h34;
    5'h0a: return 7'h44;
    5'h10: return 7'h14;
    5'h12: return 7'h28;
    5'h13: return 7'h38;
    5'h1d: return 7'h5d;
    5'h1e: return 7'h5e;
    default: return 7'h00;
  endcase
endfunction

// >>> sim/bss_boot_selector_properties.sv
/* assertions on the boot selector ports.
   assumes one sys_clk domain; bound to bss_boot_selector below. */
`timescale 1ns/10ps
module bss_props
#(
  parameter int IMAGE_BYTES = 16
)
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // inputs
  input wire logic [4:0] mode_pins,
  input wire logic       fw_valid,
  input wire logic       periph_ack,
  // decode
  input wire logic [2:0] boot_src,
  input wire logic [1:0] host_if,
  input wire logic [1:0] sys_clk_sel,
  input wire logic [4:0] mode_latched,
  // status
  input wire logic       cfg_active,
  input wire logic [7:0] cfg_step,
  input wire logic       load_active,
  input wire logic       periph_active,
  input wire logic       boot_done,
  input wire logic       mode_reserved
);
  `include "bss_expect.svh"
  logic [17:0] cnt_r;
  logic [17:0] cnt_nxt;
  // bytes taken in load, cleared only by reset
  always_comb cnt_nxt = cnt_r + 18'(load_active && fw_valid);
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) cnt_r <= 18'h0;
    else cnt_r <= cnt_nxt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cfg_run;
    cfg_active ##8 cfg_active;
  endsequence
  sequence s_to_load;
    !cfg_active && load_active;
  endsequence
  a_release_capture: assert property (
    $rose(rst_n) |-> ##[2:4] (cfg_active || mode_reserved))
    else $error("no decode after reset");
  a_strap_held: assert property (
    (load_active || periph_active || boot_done) |=> $stable(mode_latched))
    else $error("latched strap moved");
  a_decode_table: assert property (
    (cfg_active || mode_reserved) |->
      {boot_src, host_if, sys_clk_sel} == bss_expect(mode_latched))
    else $error("wrong decode");
  a_reserved_idle: assert property (
    mode_reserved |-> !(cfg_active || load_active || periph_active
      || boot_done)) else $error("reserved code started a phase");
  a_config_span: assert property (
    $rose(cfg_active) |-> s_cfg_run ##1 s_to_load)
    else $error("config span wrong");
  a_step_end: assert property (
    $fell(cfg_active) |-> cfg_step == 8'hff)
    else $error("config ended without terminator");
  a_periph_order: assert property (
    $rose(periph_active) |-> $past(load_active) && !load_active)
    else $error("periph not after load");
  a_image_count: assert property (
    $rose(periph_active) |-> cnt_r == 18'(IMAGE_BYTES))
    else $error("load ended at wrong byte count");
  a_done_on_ack: assert property (
    periph_active && periph_ack |=> boot_done && !periph_active)
    else $error("ack did not finish boot");
endmodule // bss_props
bind bss_boot_selector bss_props #(.IMAGE_BYTES(IMAGE_BYTES)) bss_props_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .mode_pins(mode_pins),
  .fw_valid(fw_valid), .periph_ack(periph_ack), .boot_src(boot_src),
  .host_if(host_if), .sys_clk_sel(sys_clk_sel),
  .mode_latched(mode_latched), .cfg_active(cfg_active),
  .cfg_step(cfg_step), .load_active(load_active),
  .periph_active(periph_active), .boot_done(boot_done),
  .mode_reserved(mode_reserved));

// >>> sim/bss_fw_source.sv
/* firmware source and peripheral side seen by the selector.
   assumes the selector's phase flags on sys_clk. */
`timescale 1ns/10ps
module bss_fw_source
#(
  parameter int IMAGE_BYTES = 16
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // pacing and phases
  input  wire logic slow,
  input  wire logic load_active,
  input  wire logic periph_active,
  // answers
  output logic      fw_valid,
  output logic      periph_ack
);
  int   sent;
  int   ack_cnt;
  logic gap;
  logic v;
  assign v = load_active && !gap && sent < IMAGE_BYTES;
  // never offers more than one image; slow leaves gaps and acks late
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sent <= 0;
      ack_cnt <= 0;
      gap <= 1'b0;
      fw_valid <= 1'b0;
      periph_ack <= 1'b0;
    end
    else
    begin
      fw_valid <= v;
      sent <= sent + int'(v);
      gap <= slow && !gap;
      ack_cnt <= periph_active ? ack_cnt + 1 : 0;
      periph_ack <= periph_active && ack_cnt == (slow ? 12 : 2);
    end
  end
endmodule // bss_fw_source

// >>> sim/bss_boot_selector_test.sv
/* self-checking bench for the boot selector.
   assumes the design under core/ and the source model beside it. */
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t mismatch", $time); end end
module bss_boot_selector_test;
  `include "bss_expect.svh"
  localparam int IMG = 16;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [4:0] mode_pins = 5'h00;
  logic       slow = 1'b0;
  logic       fw_valid, periph_ack, cfg_active, load_active;
  logic       periph_active, boot_done, mode_reserved;
  logic [2:0] boot_src;
  logic [1:0] host_if, sys_clk_sel;
  logic [4:0] mode_latched;
  logic [7:0] cfg_step;
  int         fail_count = 0;
  int         checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  bss_boot_selector #(.IMAGE_BYTES(IMG)) bss_boot_selector_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .mode_pins(mode_pins),
    .fw_valid(fw_valid), .periph_ack(periph_ack), .boot_src(boot_src),
    .host_if(host_if), .sys_clk_sel(sys_clk_sel),
    .mode_latched(mode_latched), .cfg_active(cfg_active),
    .cfg_step(cfg_step), .load_active(load_active),
    .periph_active(periph_active), .boot_done(boot_done),
    .mode_reserved(mode_reserved));
  bss_fw_source #(.IMAGE_BYTES(IMG)) bss_fw_source_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
    .load_active(load_active), .periph_active(periph_active),
    .fw_valid(fw_valid), .periph_ack(periph_ack));
  // reset with a strap, release, then follow the whole boot
  task automatic boot(input logic [4:0] m);
    int n;
    int bytes;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    mode_pins <= m;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    n = 0;
    bytes = 0;
    while (cfg_active !== 1'b1 && mode_reserved !== 1'b1 && n < 10)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK({boot_src, host_if, sys_clk_sel}, bss_expect(m))
    `CHK(mode_latched, m)
    `CHK(mode_reserved, bss_expect(m) == 7'h00)
    n = 0;
    while (boot_done !== 1'b1 && n < 300)
    begin
      @(negedge sys_clk);
      n++;
      if (load_active === 1'b1 && fw_valid === 1'b1) bytes++;
      if (cfg_active === 1'b1 && bytes > 0) `CHK(1'b0, 1'b1)
    end
    `CHK(boot_done, bss_expect(m) != 7'h00)
    `CHK(bytes, (bss_expect(m) != 7'h00) ? IMG : 0)
    `CHK(cfg_step, (bss_expect(m) != 7'h00) ? 8'hff : 8'h00)
  endtask
  task automatic test_modes;
    for (int i = 0; i < 32; i++)
      if (bss_expect(5'(i)) != 7'h00) boot(5'(i));
    $display("test_modes done");
  endtask
  task automatic test_reserved;
    for (int i = 0; i < 32; i++)
      if (bss_expect(5'(i)) == 7'h00) boot(5'(i));
    $display("test_reserved done");
  endtask
  task automatic test_slow;
    slow <= 1'b1;
    boot(5'h13);
    slow <= 1'b0;
    $display("test_slow done");
  endtask
  task automatic test_midrun_reset;
    int n;
    boot(5'h03);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    mode_pins <= 5'h0a;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    n = 0;
    while (load_active !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK(load_active, 1'b1)
    `CHK(mode_latched, 5'h0a)
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(negedge sys_clk);
    `CHK({boot_src, cfg_active, load_active, mode_latched}, 10'h000)
    boot(5'h1e);
    $display("test_midrun_reset done");
  endtask
  task automatic report_and_stop;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    test_modes();
    test_reserved();
    test_slow();
    test_midrun_reset();
    report_and_stop();
  end
endmodule // bss_boot_selector_test
